/* File: sram_host_pkg.sv */
// Package with geometry and timing constants for the asynchronous SRAM host controller.
package sram_host_pkg;

   // ************************************************************
   // Geometry
   // ************************************************************
   localparam int ADDR_W = 17;
   localparam int DATA_W = 16;
   localparam int LANE_W = 8;
   localparam int LANES = 2;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 40;
   localparam int RC_NS = 45;            // Least read cycle time.
   localparam int AA_NS = 45;            // Longest address-to-data time.
   localparam int WC_NS = 45;            // Least write cycle time.
   localparam int PWE_NS = 35;           // Least write strobe width.
   localparam int HZ_NS = 18;            // Longest release time of the memory drivers.
   localparam int LZWE_NS = 10;          // Least strobe-high to memory drive time.
   // Least times round up to whole cycles, never below one.
   localparam int READ_CYC = ((AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) + 1;
   localparam int WRITE_CYC = (PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TURN_CYC = (HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;

endpackage : sram_host_pkg

/* File: sram_pin_sync.sv */
// Two-stage synchroniser for the data pins read back from the memory.
module sram_pin_sync
   import sram_host_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // ************************************************************
   // Two flops; only the second stage is read by anyone.
   // ************************************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;

endmodule : sram_pin_sync

/* File: sram_host_ctrl.sv */
// Host controller that drives an asynchronous 128K x 16 static RAM through its pins.
// Overview of operation
// (R1) Memory holds 131072 words of 16 bits, split into lower and upper lanes.
// (R2) Write uses select and strobe low; read uses select and drive low, strobe high.
// (R3) Memory drives only the lanes whose enables are low during a read.
// (R4) Memory stores only lanes whose enables are low during a write.
// (R5) Internal write needs strobe, select and lane enable all active together.
// (R6) Write ends at first inactive edge; data is held across that edge.
// (R7) Memory is deselected when select is high or both lanes disabled.
// (R8) Memory keeps data pins released while output drive is high.
// (R9) Select rising with strobe high must not cause memory to drive.
// (R10) Host never drives data pins while the memory may be driving them.
// (R11) Host keeps write strobe high throughout a read.
// (R12) Host sets the address before select and lane enables fall.
// (R13) Host keeps lane enables steady while select is high.
// (R14) Memory enters standby within 45 ns of select rising.
// (R15) A read returns per lane the value last written to that lane.
module sram_host_ctrl
   import sram_host_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // User request
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic [LANES-1:0] req_lane,
   output logic req_ready,
   // User answer
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   // Memory pins
   output logic [ADDR_W-1:0] mem_addr,
   output logic chip_select_n,
   output logic write_strobe_n,
   output logic output_drive_n,
   output logic upper_lane_n,
   output logic lower_lane_n,
   input wire logic [DATA_W-1:0] mem_data_in,
   output logic [DATA_W-1:0] mem_data_out,
   output logic [DATA_W-1:0] mem_data_oe
);

   typedef enum logic [2:0] {IDLE, SETUP, RD_WAIT, WR_PULSE, WR_HOLD, TURN} state_e;

   localparam logic [CNT_W-1:0] READ_CNT = CNT_W'(READ_CYC);
   localparam logic [CNT_W-1:0] WRITE_CNT = CNT_W'(WRITE_CYC);
   localparam logic [CNT_W-1:0] TURN_CNT = CNT_W'(TURN_CYC);

   state_e state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic wr_reg, wr_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] wdata_reg, wdata_next;
   logic [LANES-1:0] lane_reg, lane_next;
   logic cs_n_reg, cs_n_next;
   logic we_n_reg, we_n_next;
   logic oe_n_reg, oe_n_next;
   logic [LANES-1:0] lane_n_reg, lane_n_next;
   logic drive_reg, drive_next;
   logic rsp_valid_reg, rsp_valid_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic [DATA_W-1:0] data_sync;

   // ************************************************************
   // Read-back synchroniser
   // ************************************************************
   // The data pins change without regard to clk, so they are synchronised first.
   sram_pin_sync #(.WIDTH(DATA_W)) u_sync (
      .clk(clk),
      .resetn(resetn),
      .async_in(mem_data_in),
      .sync_out(data_sync)
   );

   // ************************************************************
   // Access sequencer
   // ************************************************************
   // Each access goes SETUP, then the strobe or the read wait, then a release phase.
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      wr_next = wr_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      lane_next = lane_reg;
      cs_n_next = cs_n_reg;
      we_n_next = we_n_reg;
      oe_n_next = oe_n_reg;
      lane_n_next = lane_n_reg;
      drive_next = drive_reg;
      rsp_valid_next = 1'b0;
      rdata_next = rdata_reg;
      unique case (state_reg)
         IDLE: begin
            // Lane enables stay high while deselected, so they never toggle there.
            cs_n_next = 1'b1; // (R13)
            lane_n_next = '1; // (R13)
            we_n_next = 1'b1;
            oe_n_next = 1'b1;
            drive_next = 1'b0;
            if (req_valid && req_lane != '0) begin
               // Address and data are latched one cycle before any control falls.
               addr_next = req_addr; // (R12)
               wdata_next = req_wdata;
               lane_next = req_lane;
               wr_next = req_write;
               state_next = SETUP;
            end
         end
         SETUP: begin
            cs_n_next = 1'b0;
            lane_n_next = ~lane_reg; // (R1)
            if (wr_reg) begin
               // Strobe falls with select; output drive stays high so the memory releases.
               we_n_next = 1'b0; // (R2)
               oe_n_next = 1'b1;
               drive_next = 1'b1; // (R10)
               cnt_next = WRITE_CNT;
               state_next = WR_PULSE;
            end else begin
               we_n_next = 1'b1; // (R11)
               oe_n_next = 1'b0; // (R2)
               drive_next = 1'b0; // (R10)
               cnt_next = READ_CNT;
               state_next = RD_WAIT;
            end
         end
         RD_WAIT: begin
            if (cnt_reg == '0) begin
               // Sample covers access time plus two synchroniser stages of margin.
               rdata_next = data_sync; // (R15)
               rsp_valid_next = 1'b1;
               cs_n_next = 1'b1;
               oe_n_next = 1'b1;
               lane_n_next = '1;
               cnt_next = TURN_CNT;
               state_next = TURN;
            end else begin
               cnt_next = cnt_reg - CNT_W'(1);
            end
         end
         WR_PULSE: begin
            if (cnt_reg <= CNT_W'(1)) begin
               // Strobe alone ends the write; select and lanes stay for data hold.
               we_n_next = 1'b1; // (R6)
               state_next = WR_HOLD;
            end else begin
               cnt_next = cnt_reg - CNT_W'(1);
            end
         end
         WR_HOLD: begin
            // Data held one cycle past the terminating edge, then everything releases.
            cs_n_next = 1'b1; // (R6)
            lane_n_next = '1;
            drive_next = 1'b0;
            rsp_valid_next = 1'b1;
            cnt_next = TURN_CNT;
            state_next = TURN;
         end
         TURN: begin
            // Gives the memory time to float its drivers before the next access.
            if (cnt_reg <= CNT_W'(1)) begin
               state_next = IDLE; // (R10)
            end else begin
               cnt_next = cnt_reg - CNT_W'(1);
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= IDLE;
         cnt_reg <= '0;
         wr_reg <= 1'b0;
         addr_reg <= '0;
         wdata_reg <= '0;
         lane_reg <= '0;
         cs_n_reg <= 1'b1;
         we_n_reg <= 1'b1;
         oe_n_reg <= 1'b1;
         lane_n_reg <= '1;
         drive_reg <= 1'b0;
         rsp_valid_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         wr_reg <= wr_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         lane_reg <= lane_next;
         cs_n_reg <= cs_n_next;
         we_n_reg <= we_n_next;
         oe_n_reg <= oe_n_next;
         lane_n_reg <= lane_n_next;
         drive_reg <= drive_next;
         rsp_valid_reg <= rsp_valid_next;
         rdata_reg <= rdata_next;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Host drives only during a write, and only on the selected lanes.
   assign req_ready = (state_reg == IDLE);
   assign rsp_valid = rsp_valid_reg;
   assign rsp_rdata = rdata_reg;
   assign mem_addr = addr_reg;
   assign chip_select_n = cs_n_reg;
   assign write_strobe_n = we_n_reg;
   assign output_drive_n = oe_n_reg;
   assign lower_lane_n = lane_n_reg[0];
   assign upper_lane_n = lane_n_reg[1];
   assign mem_data_out = wdata_reg;
   assign mem_data_oe = {{LANE_W{drive_reg & lane_reg[1]}}, {LANE_W{drive_reg & lane_reg[0]}}}; // (R10)

endmodule : sram_host_ctrl

/* File: sram_host_ctrl_assertions.sv */
// Pin protocol checker for the SRAM host controller.
module sram_host_chk
   import sram_host_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Observed ports
   input wire logic rsp_valid,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic output_drive_n,
   input wire logic upper_lane_n,
   input wire logic lower_lane_n,
   input wire logic [DATA_W-1:0] mem_data_out,
   input wire logic [DATA_W-1:0] mem_data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Lane drivers follow the lane enables for the whole write overlap.
   a_write_lanes: assert property (!chip_select_n && !write_strobe_n |->
      mem_data_oe == {{LANE_W{!upper_lane_n}}, {LANE_W{!lower_lane_n}}}) else $error("bad write lanes");
   a_no_contention: assert property (!output_drive_n |-> mem_data_oe == 16'h0000)
      else $error("host drives during read");
   a_read_strobe: assert property (!output_drive_n |-> write_strobe_n)
      else $error("strobe low in read");
   // The address is set before select falls and must not move while selected.
   a_addr_steady: assert property (!chip_select_n |-> $stable(mem_addr))
      else $error("address moved");
   a_lanes_parked: assert property (chip_select_n |-> upper_lane_n && lower_lane_n)
      else $error("lanes active while idle");
   // Data is held across the strobe edge that ends the write.
   a_data_hold: assert property ($rose(write_strobe_n) && !chip_select_n |->
      $stable(mem_data_out) && $stable(mem_data_oe)) else $error("data not held");
   a_write_walk: assert property ($fell(write_strobe_n) |=>
      write_strobe_n && !chip_select_n ##1 chip_select_n && rsp_valid) else $error("write sequence");
   a_read_walk: assert property ($fell(output_drive_n) |->
      (!output_drive_n && write_strobe_n)[*4] ##1 output_drive_n && rsp_valid) else $error("read sequence");
endmodule : sram_host_chk

bind sram_host_ctrl sram_host_chk chk (.clk(clk), .resetn(resetn), .rsp_valid(rsp_valid), .mem_addr(mem_addr),
   .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
   .upper_lane_n(upper_lane_n), .lower_lane_n(lower_lane_n), .mem_data_out(mem_data_out),
   .mem_data_oe(mem_data_oe));

/* File: sram_model.sv */
// Behavioural asynchronous SRAM answering the host controller's pins.
module sram_model
   import sram_host_pkg::*;
(
   // Control and address pins
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic output_drive_n,
   input wire logic upper_lane_n,
   input wire logic lower_lane_n,
   // Data pins, split by the host into value and enable
   input wire logic [DATA_W-1:0] mem_data_out,
   input wire logic [DATA_W-1:0] mem_data_oe,
   output logic [DATA_W-1:0] mem_data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] drive;
   // Only enabled lanes drive in a read; select or output drive going high, or strobe going low, releases them at once.
   assign drive = (!chip_select_n && write_strobe_n && !output_drive_n) ?
      {{LANE_W{!upper_lane_n}}, {LANE_W{!lower_lane_n}}} : 16'h0000;
   // Released bits show the inverse of the host data, so a stale level never passes as valid.
   assign mem_data_in = (mem_data_oe & mem_data_out) | (~mem_data_oe & drive & store[mem_addr])
      | (~mem_data_oe & ~drive & ~mem_data_out);
   // Level write lasting only while select, strobe and lane overlap; deselect means standby.
   always @* begin
      if (!chip_select_n && !write_strobe_n) begin
         if (!lower_lane_n) store[mem_addr][7:0] = mem_data_in[7:0];
         if (!upper_lane_n) store[mem_addr][15:8] = mem_data_in[15:8];
      end
   end
endmodule : sram_model

/* File: async_sram_byte_lane_access_tb_top.sv */
// Self-checking bench of the SRAM host controller with a behavioural memory.
module async_sram_byte_lane_access_tb_top
   import sram_host_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic w; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic [LANES-1:0] l;} row_s;
   logic clk = 1'h0;
   logic resetn = 1'h0;
   logic req_valid = 1'h0;
   logic req_write = 1'h0;
   logic [ADDR_W-1:0] req_addr = 17'h00000;
   logic [DATA_W-1:0] req_wdata = 16'h0000;
   logic [LANES-1:0] req_lane = 2'h0;
   logic req_ready, rsp_valid, chip_select_n, write_strobe_n, output_drive_n, upper_lane_n, lower_lane_n;
   logic [DATA_W-1:0] rsp_rdata, mem_data_in, mem_data_out, mem_data_oe, q, lane_mask;
   logic [ADDR_W-1:0] mem_addr;
   int fails = 0;
   int compares = 0;
   int cycles = 0;
   // Reads carry the expected word in d; only the selected lanes are compared.
   row_s rows [9] = '{'{1'h1, 17'h00000, 16'ha5c3, 2'h3}, '{1'h0, 17'h00000, 16'ha5c3, 2'h3},
      '{1'h1, 17'h00000, 16'h1177, 2'h1}, '{1'h0, 17'h00000, 16'ha577, 2'h3},
      '{1'h1, 17'h00000, 16'h2288, 2'h2}, '{1'h0, 17'h00000, 16'h2277, 2'h3},
      '{1'h1, 17'h1ffff, 16'hbeef, 2'h3}, '{1'h0, 17'h1ffff, 16'hbeef, 2'h2},
      '{1'h0, 17'h1ffff, 16'hbeef, 2'h1}};

   sram_host_ctrl DUT (.clk, .resetn, .req_valid, .req_write, .req_addr, .req_wdata, .req_lane, .req_ready,
      .rsp_valid, .rsp_rdata, .mem_addr, .chip_select_n, .write_strobe_n, .output_drive_n, .upper_lane_n,
      .lower_lane_n, .mem_data_in, .mem_data_out, .mem_data_oe);
   sram_model model (.mem_addr, .chip_select_n, .write_strobe_n, .output_drive_n, .upper_lane_n,
      .lower_lane_n, .mem_data_out, .mem_data_oe, .mem_data_in);

   always #20 clk = ~clk;

   // A stuck handshake ends the run here rather than hanging.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         report_and_stop();
      end
   end

   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   // Present one request at a falling edge, drop it after the take, wait for the answer.
   task automatic do_op(input row_s r, output logic [DATA_W-1:0] rd);
      int n;
      n = 0;
      @(negedge clk);
      {req_valid, req_write, req_addr, req_wdata, req_lane} = {1'h1, r};
      while (req_ready !== 1'h1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      req_valid = 1'h0;
      while (rsp_valid !== 1'h1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      rd = rsp_rdata;
      // A lost answer is counted here; the run still reaches the single closing report.
      if (n >= 40) begin
         fails++;
      end
   endtask : do_op

   initial begin
      repeat (6) @(negedge clk);
      resetn = 1'h1;
      foreach (rows[i]) begin
         do_op(rows[i], q);
         if (!rows[i].w) begin
            lane_mask = {{8{rows[i].l[1]}}, {8{rows[i].l[0]}}};
            check(q & lane_mask, rows[i].d & lane_mask);
         end
      end
      // A request with no lane selected must leave the memory deselected.
      @(negedge clk);
      {req_valid, req_write, req_lane} = {1'h1, 1'h0, 2'h0};
      repeat (10) begin
         @(negedge clk);
         check({14'h0000, rsp_valid, chip_select_n}, 16'h0001);
      end
      // Reset in mid-write must park every pin at once.
      {req_write, req_addr, req_wdata, req_lane} = {1'h1, 17'h00002, 16'h5a5a, 2'h3};
      repeat (3) @(negedge clk);
      resetn = 1'h0;
      req_valid = 1'h0;
      #1;
      check({11'h000, chip_select_n, write_strobe_n, output_drive_n, upper_lane_n, lower_lane_n}, 16'h001f);
      check(mem_data_oe, 16'h0000);
      check({14'h0000, req_ready, rsp_valid}, 16'h0002);
      repeat (2) @(negedge clk);
      resetn = 1'h1;
      do_op('{1'h0, 17'h00000, 16'h2277, 2'h3}, q);
      check(q, 16'h2277);
      // The strobe had already risen before reset, so that word must have landed.
      do_op('{1'h0, 17'h00002, 16'h5a5a, 2'h3}, q);
      check(q, 16'h5a5a);
      report_and_stop();
   end
endmodule : async_sram_byte_lane_access_tb_top
